// ---- inc/mtf_regs.vh ----
// register map, parameter word layout and codes of the timer function unit
`ifndef MTF_REGS_VH
`define MTF_REGS_VH
`define MTF_HSR_ADDR  8'h80
`define MTF_IRQ_ADDR  8'h81
`define MTF_TB1_ADDR  8'h82
`define MTF_TB1X_ADDR 8'h83
`define MTF_TB2_ADDR  8'h84
`define MTF_PIN_ADDR  8'h85
`define MTF_PSC_ADDR  8'h86
`define MTF_HLT_ADDR  8'h87
`define MTF_PRM_RST   16'h0000
`define MTF_PSC_RST   16'h0000
`define MTF_TB2_LOAD  16'hFFFF
`define MTF_FUNC_LSB  0
`define MTF_PRI_LSB   3
`define MTF_TBSEL_BIT 5
`define MTF_MODE_LSB  6
`define MTF_ACT_LSB   8
`define MTF_BINC_BIT  10
`define MTF_LNK_EN    7
`define MTF_RATIO_SH  8
`define MTF_F_DISC    3'h1
`define MTF_F_CAPT    3'h2
`define MTF_F_CMP     3'h3
`define MTF_F_PWM     3'h4
`define MTF_F_LPWM    3'h5
`define MTF_F_XTOOTH  3'h6
`define MTF_DM_TRN    2'h0
`define MTF_DM_HOST   2'h1
`define MTF_DM_RATE   2'h2
`define MTF_DM_OUT    2'h3
`define MTF_CM_HOST   2'h0
`define MTF_CM_REF    2'h1
`define MTF_CM_CONT   2'h2
`define MTF_ACT_RISE  2'h1
`define MTF_ACT_FALL  2'h2
`endif

// ---- logic/mtf_timing_coprocessor.v ----
// sixteen-channel timing coprocessor: channels, scheduler, execution unit
`timescale 1ns/1ns
`include "mtf_regs.vh"
module mtf_timing_coprocessor (
    // clock and reset
    input  wire        clk_sys,
    input  wire        resetn,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output wire [15:0] reg_rdata,
    // channel pins
    input  wire [15:0] pin_in,
    output wire [15:0] pin_out,
    output wire [15:0] pin_oe,
    // position indicator pulses
    input  wire        pos_tick,
    // per-channel interrupt requests to the host
    output wire [15:0] irq_pending
);
    reg  [15:0] prm_r [0:127];
    reg  [15:0] match_r [0:15];
    reg  [22:0] stamp_r [0:15];
    reg  [15:0] hsr_r, trn_r, mat_r, lnk_r, irq_r, halt_r, men_r, pout_r, pin_prev_r;
    reg  [22:0] tb1_r;
    reg  [15:0] tb2_r, psc_r, psc_cnt_r, rdata_r;
    reg         pos_prev_r;
    reg         ex_v_r, ex_h_r, ex_t_r, ex_m_r, ex_l_r;
    reg  [3:0]  ex_ch_r;
    wire [15:0] pend, ev_trn, ev_mat, clr, hsr_set, irq_clr, cfg_wr;
    wire [31:0] pri_f;
    wire [255:0] tbv_f;
    wire        prm_acc = ~reg_addr[7];

    assign pin_out     = pout_r;
    assign irq_pending = irq_r;
    assign reg_rdata   = rdata_r;
    assign hsr_set = (reg_wr && reg_addr == `MTF_HSR_ADDR) ? reg_wdata : 16'h0000;
    assign irq_clr = (reg_wr && reg_addr == `MTF_IRQ_ADDR) ? reg_wdata : 16'h0000;

    // ------------------------------------------------------------
    // scheduler
    // ------------------------------------------------------------
    reg         sel_v;
    reg  [3:0]  sel_ch;
    reg  [1:0]  sel_lv;
    integer     k;
    always @* begin
        sel_v  = |pend;
        sel_ch = 4'h0;
        sel_lv = 2'h1;
        // downward scan: highest level wins, lowest channel within a level
        for (k = 15; k >= 0; k = k - 1) begin
            if (pend[k] && pri_f[2*k +: 2] >= sel_lv) begin
                sel_lv = pri_f[2*k +: 2];
                sel_ch = k[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // execution unit
    // ------------------------------------------------------------
    reg  [15:0] w [0:7];
    reg  [15:0] nw [0:7];
    reg  [7:0]  we;
    reg         x_pin_we, x_pin, x_arm, x_dis, x_halt, x_irq, x_pos_load, x_binc, hit;
    reg  [15:0] x_mval, x_lnk, tb, p, h, t0, cnt16;
    reg  [22:0] per, lim, prev;
    reg  [30:0] prod;
    reg  [23:0] oprod;
    reg  [7:0]  cnt8, fbyte;
    reg  [3:0]  lk;
    reg  [2:0]  fn;
    reg  [1:0]  md, act;
    reg         pin_now;
    integer     j;
    always @* begin
        for (j = 0; j < 8; j = j + 1) begin
            w[j]  = prm_r[{ex_ch_r, j[2:0]}];
            nw[j] = w[j];
        end
        we = 8'h00;
        x_pin_we = 1'b0; x_pin = 1'b0; x_arm = 1'b0; x_dis = 1'b0; x_halt = 1'b0;
        x_irq = 1'b0; x_pos_load = 1'b0; x_binc = 1'b0; hit = 1'b0;
        x_mval = 16'h0000; x_lnk = 16'h0000; lk = 4'h0;
        fn  = w[0][`MTF_FUNC_LSB +: 3];
        md  = w[0][`MTF_MODE_LSB +: 2];
        act = w[0][`MTF_ACT_LSB +: 2];
        tb  = tbv_f[16*ex_ch_r +: 16];
        pin_now = pout_r[ex_ch_r];
        p = w[1];
        h = w[2];
        t0 = tb;
        cnt16 = w[3] + 16'h0001;
        prev = {w[2][6:0], w[1]};
        per  = stamp_r[ex_ch_r] - {w[6][6:0], w[5]};
        prod = prev * w[4][7:0];
        lim  = prod[30:`MTF_RATIO_SH];
        oprod = prm_r[w[3][6:0]] * w[4][7:0];
        cnt8  = w[2][15:8] + 8'h01;
        fbyte = w[7][0] ? prm_r[w[7][7:1]][15:8] : prm_r[w[7][7:1]][7:0];
        if (ex_v_r) begin
            case (fn)
            `MTF_F_DISC: begin
                if (md == `MTF_DM_OUT) begin
                    if (ex_h_r) begin
                        x_pin_we = 1'b1;
                        x_pin    = w[0][`MTF_ACT_LSB];
                    end
                end else begin
                    if ((md == `MTF_DM_TRN && ex_t_r) || (md == `MTF_DM_HOST && ex_h_r)
                        || (md == `MTF_DM_RATE && ex_m_r)) begin
                        nw[1] = {pin_in[ex_ch_r], w[1][15:1]};
                        we[1] = 1'b1;
                    end
                    if (md == `MTF_DM_RATE && (ex_h_r || ex_m_r)) begin
                        x_arm  = 1'b1;
                        x_mval = (ex_m_r ? match_r[ex_ch_r] : tb) + w[2];
                    end
                end
            end
            `MTF_F_CAPT: begin
                if (ex_h_r) begin
                    nw[3] = 16'h0000;
                    we[3] = 1'b1;
                end else if (ex_t_r) begin
                    hit = ~md[1] | (cnt16 >= w[2]);
                    we[3] = 1'b1;
                    nw[3] = hit ? 16'h0000 : cnt16;
                    if (hit) begin
                        nw[1] = stamp_r[ex_ch_r][15:0];
                        we[1] = 1'b1;
                        x_irq = 1'b1;
                        x_halt = md[0];
                        x_binc = w[0][`MTF_BINC_BIT];
                        if (w[4][`MTF_LNK_EN]) begin
                            for (j = 0; j < 8; j = j + 1) begin
                                lk = w[4][3:0] + j[3:0];
                                if (j[2:0] <= w[4][6:4])
                                    x_lnk[lk] = 1'b1;
                            end
                        end
                    end
                end
            end
            `MTF_F_CMP: begin
                case (md)
                `MTF_CM_HOST: begin
                    if (ex_h_r) begin
                        x_pin_we = 1'b1;
                        x_pin = (act == `MTF_ACT_RISE) ? 1'b1 :
                                (act == `MTF_ACT_FALL) ? 1'b0 : ~pin_now;
                        x_arm = 1'b1;
                        x_mval = tb + w[1];
                    end else if (ex_m_r) begin
                        x_pin_we = 1'b1;
                        x_pin = ~pin_now;
                        x_dis = 1'b1;
                    end
                end
                `MTF_CM_REF: begin
                    if (ex_h_r) begin
                        x_arm = 1'b1;
                        x_mval = w[2] + w[1];
                    end else if (ex_m_r) begin
                        x_pin_we = 1'b1;
                        x_pin = (act == `MTF_ACT_RISE) ? 1'b1 :
                                (act == `MTF_ACT_FALL) ? 1'b0 : ~pin_now;
                        x_dis = 1'b1;
                    end
                end
                `MTF_CM_CONT: begin
                    if (ex_l_r) begin
                        nw[6] = oprod[23:8];
                        we[6] = 1'b1;
                        x_arm = 1'b1;
                        x_mval = tb + oprod[23:8];
                    end else if (ex_m_r) begin
                        x_pin_we = 1'b1;
                        x_pin = ~pin_now;
                        x_arm = 1'b1;
                        x_mval = match_r[ex_ch_r] + w[6];
                    end
                end
                default: x_dis = 1'b0;
                endcase
            end
            `MTF_F_PWM, `MTF_F_LPWM: begin
                if (fn == `MTF_F_LPWM && ex_l_r) begin
                    x_pin_we = 1'b1;
                    x_pin = 1'b0;
                    x_arm = 1'b1;
                    x_mval = tb + w[6];
                    nw[5] = tb + w[6];
                    we[5] = 1'b1;
                end else if ((ex_h_r && !(md[0] && men_r[ex_ch_r]))
                             || (ex_m_r && match_r[ex_ch_r] == w[5])) begin
                    // rising edge picks up period and high time afresh
                    if (ex_m_r && !ex_h_r)
                        t0 = match_r[ex_ch_r];
                    x_pin_we = 1'b1;
                    x_pin = (h != 16'h0000);
                    x_arm = 1'b1;
                    x_mval = (h == 16'h0000 || h >= p) ? t0 + p : t0 + h;
                    nw[5] = t0 + p;
                    we[5] = 1'b1;
                end else if (ex_m_r) begin
                    x_pin_we = 1'b1;
                    x_pin = 1'b0;
                    x_arm = 1'b1;
                    x_mval = w[5];
                end
            end
            `MTF_F_XTOOTH: begin
                if (ex_t_r) begin
                    nw[5] = stamp_r[ex_ch_r][15:0];
                    nw[6] = {w[6][15:7], stamp_r[ex_ch_r][22:16]};
                    we[6:5] = 2'h3;
                    we[2] = 1'b1;
                    if (per < lim) begin
                        x_irq = 1'b1;
                        nw[2] = {cnt8, w[2][7:0]};
                        if (!md[0] && cnt8 >= w[3][7:0]) begin
                            x_pos_load = 1'b1;
                            nw[2] = {8'h00, w[2][7:0]};
                        end
                        if (md[0] && fbyte != 8'h00)
                            x_pos_load = 1'b1;
                    end else begin
                        nw[1] = per[15:0];
                        nw[2] = {w[2][15:7], per[22:16]};
                        we[1] = 1'b1;
                    end
                end
            end
            default: x_dis = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // per-channel event hardware
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : ch
            wire [15:0] cfg = prm_r[g*8];
            wire [2:0]  cfn = cfg[`MTF_FUNC_LSB +: 3];
            wire [15:0] tbv = cfg[`MTF_TBSEL_BIT] ? tb2_r : tb1_r[15:0];
            wire        mine = ex_v_r && ex_ch_r == g;
            assign tbv_f[16*g +: 16] = tbv;
            assign pri_f[2*g +: 2] = cfg[`MTF_PRI_LSB +: 2];
            assign cfg_wr[g] = reg_wr && prm_acc && reg_addr[6:0] == g*8;
            assign clr[g] = (sel_v && sel_ch == g) || cfg_wr[g];
            assign ev_trn[g] = pin_in[g] ^ pin_prev_r[g];
            assign ev_mat[g] = men_r[g] && !mat_r[g] && tbv == match_r[g];
            assign pend[g] = cfg[`MTF_PRI_LSB +: 2] != 2'h0 &&
                             (hsr_r[g] || (~halt_r[g] && (trn_r[g] | mat_r[g] | lnk_r[g])));
            assign pin_oe[g] = cfn == `MTF_F_CMP || cfn == `MTF_F_PWM || cfn == `MTF_F_LPWM
                || (cfn == `MTF_F_DISC && cfg[`MTF_MODE_LSB +: 2] == `MTF_DM_OUT);
            always @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    pin_prev_r[g] <= 1'b0;
                    stamp_r[g] <= 23'h000000;
                    hsr_r[g] <= 1'b0; trn_r[g] <= 1'b0; mat_r[g] <= 1'b0; lnk_r[g] <= 1'b0;
                    irq_r[g] <= 1'b0; halt_r[g] <= 1'b0; men_r[g] <= 1'b0;
                    pout_r[g] <= 1'b0; match_r[g] <= 16'h0000;
                end else begin
                    pin_prev_r[g] <= pin_in[g];
                    if (ev_trn[g])
                        stamp_r[g] <= cfg[`MTF_TBSEL_BIT] ? {7'h00, tb2_r} : tb1_r;
                    // a new event in the clearing cycle is kept
                    hsr_r[g] <= hsr_set[g] | (hsr_r[g] & ~clr[g]);
                    trn_r[g] <= ev_trn[g] | (trn_r[g] & ~clr[g]);
                    mat_r[g] <= ev_mat[g] | (mat_r[g] & ~clr[g]);
                    lnk_r[g] <= (x_lnk[g] & ex_v_r) | (lnk_r[g] & ~clr[g]);
                    irq_r[g] <= x_irq & mine | (irq_r[g] & ~irq_clr[g]);
                    if (mine && x_halt)
                        halt_r[g] <= 1'b1;
                    else if (cfg_wr[g] || hsr_set[g])
                        halt_r[g] <= 1'b0;
                    // stop repeat matches while the time base dwells on the value
                    if (mine && x_arm) begin
                        men_r[g] <= 1'b1;
                        match_r[g] <= x_mval;
                    end else if ((mine && x_dis) || (sel_v && sel_ch == g && mat_r[g]))
                        men_r[g] <= 1'b0;
                    if (mine && x_pin_we)
                        pout_r[g] <= x_pin;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // dispatch, parameter storage, time bases, register reads
    // ------------------------------------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ex_v_r <= 1'b0; ex_ch_r <= 4'h0;
            ex_h_r <= 1'b0; ex_t_r <= 1'b0; ex_m_r <= 1'b0; ex_l_r <= 1'b0;
        end else begin
            ex_v_r  <= sel_v;
            ex_ch_r <= sel_ch;
            ex_h_r  <= hsr_r[sel_ch];
            ex_t_r  <= trn_r[sel_ch];
            ex_m_r  <= mat_r[sel_ch];
            ex_l_r  <= lnk_r[sel_ch];
        end
    end

    integer m;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (m = 0; m < 128; m = m + 1)
                prm_r[m] <= `MTF_PRM_RST;
        end else begin
            for (m = 0; m < 8; m = m + 1)
                if (ex_v_r && we[m])
                    prm_r[{ex_ch_r, m[2:0]}] <= nw[m];
            if (ex_v_r && x_binc) begin
                if (w[4][8])
                    prm_r[w[4][15:9]][15:8] <= prm_r[w[4][15:9]][15:8] + 8'h01;
                else
                    prm_r[w[4][15:9]][7:0] <= prm_r[w[4][15:9]][7:0] + 8'h01;
            end
            // host write lands last so software always sees its own value
            if (reg_wr && prm_acc)
                prm_r[reg_addr[6:0]] <= reg_wdata;
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tb1_r <= 23'h000000; tb2_r <= 16'h0000; psc_r <= `MTF_PSC_RST;
            psc_cnt_r <= 16'h0000; pos_prev_r <= 1'b0; rdata_r <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == `MTF_PSC_ADDR)
                psc_r <= reg_wdata;
            if (psc_cnt_r >= psc_r) begin
                psc_cnt_r <= 16'h0000;
                tb1_r <= tb1_r + 23'h000001;
            end else
                psc_cnt_r <= psc_cnt_r + 16'h0001;
            pos_prev_r <= pos_tick;
            if (ex_v_r && x_pos_load)
                tb2_r <= `MTF_TB2_LOAD;
            else if (pos_tick && !pos_prev_r)
                tb2_r <= tb2_r + 16'h0001;
            if (!reg_rd)
                rdata_r <= 16'h0000;
            else if (prm_acc)
                rdata_r <= prm_r[reg_addr[6:0]];
            else begin
                case (reg_addr)
                `MTF_HSR_ADDR:  rdata_r <= hsr_r;
                `MTF_IRQ_ADDR:  rdata_r <= irq_r;
                `MTF_TB1_ADDR:  rdata_r <= tb1_r[15:0];
                `MTF_TB1X_ADDR: rdata_r <= {9'h000, tb1_r[22:16]};
                `MTF_TB2_ADDR:  rdata_r <= tb2_r;
                `MTF_PIN_ADDR:  rdata_r <= pin_in;
                `MTF_PSC_ADDR:  rdata_r <= psc_r;
                `MTF_HLT_ADDR:  rdata_r <= halt_r;
                default:        rdata_r <= 16'h0000;
                endcase
            end
        end
    end
endmodule // mtf_timing_coprocessor

// ---- test/mtf_chk.sv ----
// port assertions for the timing coprocessor
`timescale 1ns/1ns
`include "mtf_regs.vh"
module mtf_chk (
    // clock and reset
    input wire        clk_sys,
    input wire        resetn,
    // register port
    input wire [7:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    // pins and requests
    input wire [15:0] pin_in,
    input wire [15:0] pin_out,
    input wire [15:0] pin_oe,
    input wire        pos_tick,
    input wire [15:0] irq_pending
);
    // ----------
    // helpers
    // ----------
    // prescaler shadow: the rate check only holds while it is zero
    logic [15:0] psc_r;
    wire  [15:0] clr_w = (reg_wr && reg_addr == `MTF_IRQ_ADDR) ? reg_wdata : 16'h0000;
    wire         cfg_w = reg_wr && reg_addr < 8'h80;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            psc_r <= `MTF_PSC_RST;
        else if (reg_wr && reg_addr == `MTF_PSC_ADDR)
            psc_r <= reg_wdata;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ----------
    // assertions
    // ----------
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    unmapped_read_a: assert property ($past(reg_rd) && $past(reg_addr) > 8'h87
        |-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    reset_quiet_a: assert property ($rose(resetn)
        |-> pin_out == 16'h0000 && pin_oe == 16'h0000 && irq_pending == 16'h0000)
        else $error("outputs active after reset");
    irq_hold_a: assert property ($past(cfg_w)
        || ($past(irq_pending) & ~irq_pending & ~$past(clr_w)) == 16'h0000)
        else $error("request dropped without clear");
    oe_by_config_a: assert property (!$stable(pin_oe)
        |-> $past(cfg_w) && $past(reg_addr[2:0]) == 3'h0)
        else $error("pin enable moved without setup write");
    irq_readback_a: assert property ($past(reg_rd) && $past(reg_addr) == `MTF_IRQ_ADDR
        |-> reg_rdata == $past(irq_pending)) else $error("pending read mismatch");
    psc_readback_a: assert property ($past(reg_rd) && $past(reg_addr) == `MTF_PSC_ADDR
        |-> reg_rdata == $past(psc_r)) else $error("prescaler read mismatch");
    base_width_a: assert property ($past(reg_rd) && $past(reg_addr) == `MTF_TB1X_ADDR
        |-> reg_rdata[15:7] == 9'h000) else $error("time base wider than 23 bits");
    base_rate_a: assert property ($past(reg_rd) && $past(reg_rd, 3)
        && $past(reg_addr) == `MTF_TB1_ADDR && $past(reg_addr, 3) == `MTF_TB1_ADDR
        && $past(psc_r, 3) == 16'h0000 && !$past(reg_wr) && !$past(reg_wr, 2)
        && !$past(reg_wr, 3) |-> reg_rdata == $past(reg_rdata, 2) + 16'h0002)
        else $error("internal base rate wrong");
endmodule // mtf_chk

bind mtf_timing_coprocessor mtf_chk u_chk (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pos_tick(pos_tick), .irq_pending(irq_pending));

// ---- test/mtf_pin_model.sv ----
// sensor and actuator model on the channel pins
`timescale 1ns/1ns
module mtf_pin_model (
    // clock
    input wire          clk_sys,
    // channel pins
    input wire [15:0]   pin_out,
    input wire [15:0]   pin_oe,
    output logic [15:0] pin_in,
    // position indicator
    output logic        pos_tick
);
    logic [15:0] ext_r = 16'h0000;
    initial pos_tick = 1'b0;
    // a driven pin reads back its own level, the others see the sensor
    always @* pin_in = (pin_oe & pin_out) | (~pin_oe & ext_r);
    task automatic set_lvl(input int ch, input logic lv);
        @(posedge clk_sys);
        ext_r[ch] <= lv;
    endtask
    // one tick per two clocks so every rising edge is seen
    task automatic ticks(input int cnt);
        repeat (cnt) begin
            @(posedge clk_sys);
            pos_tick <= 1'b1;
            @(posedge clk_sys);
            pos_tick <= 1'b0;
        end
    endtask
endmodule // mtf_pin_model

// ---- test/tb_top.sv ----
// self-checking bench for the timing coprocessor
`timescale 1ns/1ns
`include "mtf_regs.vh"
module tb_top;
    logic        clk_sys   = 1'b0;
    logic        resetn    = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    wire  [15:0] reg_rdata;
    wire  [15:0] pin_in;
    wire  [15:0] pin_out;
    wire  [15:0] pin_oe;
    wire  [15:0] irq_pending;
    wire         pos_tick;
    int          failures  = 0;
    int          cmp_count = 0;
    int          n;
    logic [15:0] v;
    logic [15:0] t0;
    logic [15:0] t1;
    logic [15:0] hx [3] = '{16'h8000, 16'h4000, 16'hA000};
    logic [15:0] hi [3] = '{16'h0004, 16'h0000, 16'h000A};

    always #50 clk_sys = ~clk_sys;

    mtf_timing_coprocessor u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pos_tick(pos_tick), .irq_pending(irq_pending));
    mtf_pin_model u_pins (
        .clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
        .pos_tick(pos_tick));

    // ----------
    // bus and check tasks
    // ----------
    function automatic logic [15:0] b(input logic x);
        return {15'h0000, x};
    endfunction
    function automatic logic [7:0] pa(input int ch, input int w);
        return 8'(ch * 8 + w);
    endfunction
    task automatic clk(input int c);
        repeat (c) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        chk(nm, d, e);
    endtask
    // bounded wait on a pin level or a service request bit
    task automatic wait_on(input int ch, input logic lv, input logic irq);
        n = 0;
        while ((irq ? irq_pending[ch] : pin_out[ch]) !== lv && n < 60) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----------
    // tests
    // ----------
    initial begin
        #3000000;
        failures++;
        $display("ERROR watchdog expected finish seen hang");
        close_out();
    end
    initial begin
        clk(2);
        resetn <= 1'b1;
        rc("irq reset", `MTF_IRQ_ADDR, 16'h0000);
        rc("psc reset", `MTF_PSC_ADDR, `MTF_PSC_RST);
        rc("param reset", pa(5, 0), `MTF_PRM_RST);
        wr(8'h9C, 16'hBEEF);
        rc("unmapped", 8'h9C, 16'h0000);
        rd(`MTF_TB1X_ADDR, v);
        chk("base high", v & 16'hFF80, 16'h0000);
        $display("done reset map");
        rd(`MTF_TB1_ADDR, t0);
        rd(`MTF_TB1_ADDR, t1);
        chk("base psc0", t1 - t0, 16'h0002);
        wr(`MTF_PSC_ADDR, 16'h0001);
        rc("psc back", `MTF_PSC_ADDR, 16'h0001);
        rd(`MTF_TB1_ADDR, t0);
        clk(2);
        rd(`MTF_TB1_ADDR, t1);
        chk("base psc1", t1 - t0, 16'h0002);
        wr(`MTF_PSC_ADDR, 16'h0000);
        rd(`MTF_TB2_ADDR, t0);
        u_pins.ticks(3);
        clk(4);
        rd(`MTF_TB2_ADDR, t1);
        chk("pos base", t1 - t0, 16'h0003);
        $display("done time bases");
        wr(pa(2, 0), 16'h01C9);
        clk(10);
        chk("out enable", b(pin_oe[2]), 16'h0001);
        chk("out no req", b(pin_out[2]), 16'h0000);
        wr(`MTF_HSR_ADDR, 16'h0004);
        wait_on(2, 1'b1, 1'b0);
        chk("out high", b(pin_out[2]), 16'h0001);
        wr(pa(2, 0), 16'h00C9);
        clk(10);
        chk("out kept", b(pin_out[2]), 16'h0001);
        wr(`MTF_HSR_ADDR, 16'h0004);
        wait_on(2, 1'b0, 1'b0);
        chk("out low", b(pin_out[2]), 16'h0000);
        $display("done discrete out");
        wr(pa(3, 0), 16'h0049);
        for (int i = 0; i < 3; i++) begin
            u_pins.set_lvl(3, ~i[0]);
            clk(3);
            wr(`MTF_HSR_ADDR, 16'h0008);
            clk(8);
            rc("host history", pa(3, 1), hx[i]);
        end
        wr(pa(4, 0), 16'h0009);
        u_pins.set_lvl(4, 1'b1);
        clk(10);
        rc("edge history", pa(4, 1), 16'h8000);
        u_pins.set_lvl(4, 1'b0);
        clk(30);
        rc("edge history 2", pa(4, 1), 16'h4000);
        $display("done discrete in");
        wr(`MTF_IRQ_ADDR, 16'hFFFF);
        wr(pa(5, 0), 16'h005A);
        rd(`MTF_TB1_ADDR, t0);
        u_pins.set_lvl(5, 1'b1);
        wait_on(5, 1'b1, 1'b1);
        rd(`MTF_TB1_ADDR, t1);
        rd(pa(5, 1), v);
        chk("stamp", b(v >= t0 && v <= t1), 16'h0001);
        clk(20);
        chk("irq held", b(irq_pending[5]), 16'h0001);
        wr(`MTF_IRQ_ADDR, 16'h0020);
        u_pins.set_lvl(5, 1'b0);
        clk(20);
        chk("halted", b(irq_pending[5]), 16'h0000);
        wr(pa(5, 2), 16'h0003);
        wr(pa(5, 3), 16'h0000);
        wr(pa(5, 0), 16'h009A);
        for (int i = 0; i < 3; i++) begin
            u_pins.set_lvl(5, ~i[0]);
            clk(10);
            chk("count irq", b(irq_pending[5]), b(i == 2));
        end
        $display("done capture");
        wr(pa(6, 1), 16'h000A);
        wr(pa(6, 0), 16'h000C);
        for (int i = 0; i < 3; i++) begin
            wr(pa(6, 2), hi[i]);
            wr(`MTF_HSR_ADDR, 16'h0040);
            clk(25);
            t0 = 16'h0000;
            repeat (40) begin
                @(posedge clk_sys);
                #1;
                t0 = t0 + b(pin_out[6]);
            end
            chk("pwm high", t0, hi[i] * 16'h0004);
        end
        chk("pwm enable", b(pin_oe[6]), 16'h0001);
        $display("done pwm");
        rd(`MTF_TB1_ADDR, t0);
        wr(pa(7, 1), 16'h0010);
        wr(pa(7, 2), t0 + 16'h0020);
        wr(pa(7, 0), 16'h014B);
        wr(`MTF_HSR_ADDR, 16'h0080);
        clk(20);
        chk("cmp early", b(pin_out[7]), 16'h0000);
        clk(30);
        chk("cmp rise", b(pin_out[7]), 16'h0001);
        chk("cmp enable", b(pin_oe[7]), 16'h0001);
        $display("done compare");
        close_out();
    end
endmodule // tb_top
